// file: design/dprc_defs.svh
// Constants for the dual-port RAM controller.
// Assumes a 10 MHz board clock and jumpers that stay static.
//
// Overview of operation
// - Refresh always wins arbitration over processor and bus requests.
// - On a tie between processor and bus, the processor is granted.
// - Processor and system-bus addresses are decoded by separate logic.
// - The processor sees RAM starting at address zero.
// - Bus window base is jumper-selected on any 8K boundary in 1 MB.
// - A contiguous run of 8K or 16K segments can be hidden from the bus.
// - The bus port takes byte and 16-bit word accesses.
// - Processor accesses use the full 16-bit data path.
// - Serve 32K base RAM, 64K with expansion, both maps adjusted.
// - Processor accesses never use the system bus.
// - Battery power blocks accesses while refresh keeps running.
// - Bus transfers complete by request and acknowledge, no fixed count.
`ifndef DPRC_DEFS_SVH
`define DPRC_DEFS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DPRC_CLK_PERIOD_NS   100
`define DPRC_REFRESH_NS      15600
`define DPRC_REFRESH_CYCLES  (`DPRC_REFRESH_NS / `DPRC_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Memory geometry
// ----------------------------------------------------------------
`define DPRC_BASE_WORDS_LOG  14
`define DPRC_EXP_WORDS_LOG   15
`define DPRC_SEG_LOG         13
`define DPRC_BUS_ADDR_W      20

`endif

// file: design/dprc_pkg.sv
// Types for the dual-port RAM controller.
// Assumes nothing beyond the defs header.
package dprc_pkg;
   typedef enum logic [1:0] {
      DPRC_IDLE,
      DPRC_REFRESH,
      DPRC_LOCAL,
      DPRC_BUS
   } dprc_state_t;
endpackage

// file: design/dprc_ctrl.sv
// Dual-port controller for on-board dynamic RAM.
// Assumes the processor side is synchronous to clk; bus and jumper pins
// are asynchronous and pass two flip-flops first.
`timescale 1ns/1ps
`include "dprc_defs.svh"

module dprc_ctrl
   import dprc_pkg::*;
#(
   parameter int REFRESH_CYCLES = `DPRC_REFRESH_CYCLES
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // Board straps and power
   input  wire logic        expansion_fitted,
   input  wire logic        battery_power,
   input  wire logic [6:0]  bus_base_jumper,
   input  wire logic [2:0]  hide_first_seg,
   input  wire logic [2:0]  hide_last_seg,
   input  wire logic        hide_enable,
   // Local processor port
   input  wire logic        local_req,
   input  wire logic        local_write,
   input  wire logic [15:0] local_addr,
   input  wire logic [15:0] local_wdata,
   output logic             local_ack,
   output logic [15:0]      local_rdata,
   // System bus slave port
   input  wire logic        bus_req,
   input  wire logic        bus_write,
   input  wire logic        bus_byte,
   input  wire logic [19:0] bus_addr,
   input  wire logic [15:0] bus_wdata,
   output logic             bus_ack,
   output logic [15:0]      bus_rdata,
   // Refresh observation
   output logic             refresh_busy
);

   localparam int AW = `DPRC_EXP_WORDS_LOG;
   localparam int DEPTH = 1 << AW;

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   localparam int SW = 2 + 7 + 3 + 3 + 1 + 1 + 1 + 1 + 20 + 16;
   logic [SW-1:0] sync_a;
   logic [SW-1:0] sync_b;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sync_a <= '0;
         sync_b <= '0;
      end else begin
         sync_a <= {expansion_fitted, battery_power, bus_base_jumper,
                    hide_first_seg, hide_last_seg, hide_enable, bus_req,
                    bus_write, bus_byte, bus_addr, bus_wdata};
         sync_b <= sync_a;
      end
   end
   logic        s_exp;
   logic        s_batt;
   logic [6:0]  s_base;
   logic [2:0]  s_first;
   logic [2:0]  s_last;
   logic        s_hide;
   logic        s_req;
   logic        s_write;
   logic        s_byte;
   logic [19:0] s_addr;
   logic [15:0] s_wdata;
   assign {s_exp, s_batt, s_base, s_first, s_last, s_hide, s_req,
           s_write, s_byte, s_addr, s_wdata} = sync_b;

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   // Byte offset of a bus access into the window, 1 MB wraps
   logic [19:0] bus_off;
   assign bus_off = s_addr - {s_base, 13'h0000};

   function automatic logic in_size(input logic [19:0] off,
                                    input logic exp);
      in_size = exp ? (off[19:16] == 4'h0)
                    : (off[19:15] == 5'h00);
   endfunction

   // Segment index scales with RAM size: 8K base, 16K expanded
   logic [2:0] seg;
   assign seg = s_exp ? {1'b0, bus_off[15:14]}
                      : {1'b0, bus_off[14:13]};
   logic hidden;
   assign hidden = s_hide && seg >= s_first && seg <= s_last;

   logic bus_hit;
   assign bus_hit = s_req && in_size(bus_off, s_exp) && !hidden;

   // Local map always starts at zero
   logic local_hit;
   assign local_hit = local_req &&
                      in_size({4'h0, local_addr}, s_exp);

   // ----------------------------------------------------------------
   // Refresh timer
   // ----------------------------------------------------------------
   logic [15:0] ref_cnt;
   logic        ref_pend;
   logic        ref_grant;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ref_cnt <= '0;
      end else if (ref_cnt == 16'(REFRESH_CYCLES - 1)) begin
         ref_cnt <= '0;
      end else begin
         ref_cnt <= ref_cnt + 16'h0001;
      end
   end
   // Set wins over grant so no tick is lost; keeps running on battery
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ref_pend <= 1'b0;
      end else if (ref_cnt == 16'(REFRESH_CYCLES - 1)) begin
         ref_pend <= 1'b1;
      end else if (ref_grant) begin
         ref_pend <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Arbiter
   // ----------------------------------------------------------------
   dprc_state_t state;
   logic        bus_done;
   logic        local_go;
   logic        bus_go;
   assign ref_grant = (state == DPRC_IDLE) && ref_pend;
   assign local_go  = (state == DPRC_IDLE) && !ref_pend && !s_batt &&
                      local_hit && !local_ack;
   assign bus_go    = (state == DPRC_IDLE) && !ref_pend && !s_batt &&
                      !local_hit && bus_hit && !bus_done;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state <= DPRC_IDLE;
      end else begin
         unique case (state)
            DPRC_IDLE: begin
               if (ref_grant) begin
                  state <= DPRC_REFRESH;
               end else if (local_go) begin
                  state <= DPRC_LOCAL;
               end else if (bus_go) begin
                  state <= DPRC_BUS;
               end
            end
            DPRC_REFRESH: begin
               state <= DPRC_IDLE;
            end
            DPRC_LOCAL: begin
               state <= DPRC_IDLE;
            end
            DPRC_BUS: begin
               state <= DPRC_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         refresh_busy <= 1'b0;
      end else begin
         refresh_busy <= ref_grant;
      end
   end

   // ----------------------------------------------------------------
   // RAM array, two byte lanes
   // ----------------------------------------------------------------
   logic [7:0] ram_lo [DEPTH];
   logic [7:0] ram_hi [DEPTH];
   logic [AW-1:0] l_idx;
   logic [AW-1:0] b_idx;
   assign l_idx = local_addr[AW:1];
   assign b_idx = bus_off[AW:1];

   // Local port: full word, never touches the bus
   always_ff @(posedge clk) begin
      if (local_go && local_write) begin
         ram_lo[l_idx] <= local_wdata[7:0];
         ram_hi[l_idx] <= local_wdata[15:8];
      end else if (bus_go && s_write) begin
         if (!s_byte || !bus_off[0]) begin
            ram_lo[b_idx] <= s_wdata[7:0];
         end
         if (!s_byte || bus_off[0]) begin
            ram_hi[b_idx] <= s_byte ? s_wdata[7:0] : s_wdata[15:8];
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         local_ack   <= 1'b0;
         local_rdata <= '0;
      end else begin
         local_ack <= local_go;
         if (local_go) begin
            local_rdata <= {ram_hi[l_idx], ram_lo[l_idx]};
         end
      end
   end

   // ----------------------------------------------------------------
   // Bus handshake: ack holds until the request drops
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         bus_done  <= 1'b0;
         bus_ack   <= 1'b0;
         bus_rdata <= '0;
      end else begin
         if (!s_req) begin
            bus_done <= 1'b0;
            bus_ack  <= 1'b0;
         end else if (bus_go) begin
            bus_done <= 1'b1;
            bus_ack  <= 1'b1;
            // Byte read of odd address steers high lane to low bits
            bus_rdata <= (s_byte && bus_off[0]) ?
                         {8'h00, ram_hi[b_idx]} :
                         {ram_hi[b_idx], ram_lo[b_idx]};
         end
      end
   end

endmodule

// file: bench/dprc_properties.sv
// Port checker for the dual-port RAM controller.
// Assumes it is bound onto dprc_ctrl.
`timescale 1ns/1ps
module dprc_properties #(
   parameter int REFRESH_CYCLES = 8
) (
   // Clock, reset, straps
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        battery_power,
   input wire logic        expansion_fitted,
   // Local and bus handshakes
   input wire logic        local_req,
   input wire logic [15:0] local_addr,
   input wire logic        local_ack,
   input wire logic        bus_req,
   input wire logic        bus_ack,
   input wire logic        refresh_busy
);
   int gap;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // Slack covers one bus or local slot in progress
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         gap <= 0;
      end else if (refresh_busy) begin
         gap <= 0;
      end else begin
         gap <= gap + 1;
      end
   end
   // Request seen through the two-stage synchroniser
   sequence req_held;
      $past(bus_req, 3);
   endsequence
   sequence req_drop;
      bus_ack && $fell(bus_req);
   endsequence
   chk_refresh_gap: assert property (gap < 2 * REFRESH_CYCLES + 20)
      else $error("refresh starved");
   chk_refresh_alone: assert property (refresh_busy |-> !local_ack)
      else $error("local ack during refresh");
   chk_local_pulse: assert property (local_ack |=> !local_ack)
      else $error("local ack longer than one cycle");
   chk_local_cause: assert property (local_ack |-> $past(local_req))
      else $error("local ack without request");
   chk_local_range: assert property (local_ack |->
      expansion_fitted || !$past(local_addr[15])) else $error("ack past ram");
   chk_battery_block: assert property (battery_power[*5] |-> !local_ack)
      else $error("access under battery power");
   chk_battery_bus: assert property (battery_power[*5] |->
      !$rose(bus_ack)) else $error("bus access under battery power");
   chk_bus_priority: assert property ($rose(bus_ack) |->
      !$past(local_req) || (!expansion_fitted && $past(local_addr[15])))
      else $error("bus granted over local request");
   chk_bus_cause: assert property ($rose(bus_ack) |-> req_held)
      else $error("bus ack without request");
   chk_bus_hold: assert property (bus_ack && bus_req |=> bus_ack)
      else $error("bus ack dropped early");
   chk_bus_release: assert property (req_drop |-> ##[1:4] !bus_ack)
      else $error("bus ack stuck");
endmodule
bind dprc_ctrl dprc_properties #(.REFRESH_CYCLES(REFRESH_CYCLES)) i_props (
   .clk, .reset, .battery_power, .expansion_fitted, .local_req, .local_addr,
   .local_ack, .bus_req, .bus_ack, .refresh_busy);

// file: bench/dprc_bus_master.sv
// System-bus master model for the controller's slave port.
// Assumes the bench calls xfer one transfer at a time.
`timescale 1ns/1ps
module dprc_bus_master (
   // Clock
   input wire logic         clk,
   // Slave answer
   input wire logic         bus_ack,
   input wire logic [15:0]  bus_rdata,
   // Request
   output logic             bus_req = 1'b0,
   output logic             bus_write = 1'b0,
   output logic             bus_byte = 1'b0,
   output logic [19:0]      bus_addr = 20'h00000,
   output logic [15:0]      bus_wdata = 16'h0000
);
   task automatic xfer(input logic wr, bt, input logic [19:0] a,
      input logic [15:0] w, output logic got, output logic [15:0] r);
      int i;
      got = 1'b0;
      @(posedge clk) #1;
      bus_write = wr;
      bus_byte = bt;
      bus_addr = a;
      bus_wdata = w;
      bus_req = 1'b1;
      for (i = 0; i < 30 && !got; i++) begin
         @(posedge clk);
         got = (bus_ack === 1'b1);
      end
      r = bus_rdata;
      #1 bus_req = 1'b0;
      // Released address, data and write lines must not keep stale values
      bus_addr = ~a;
      bus_wdata = ~w;
      bus_write = ~wr;
      for (i = 0; i < 30 && bus_ack === 1'b1; i++) @(posedge clk) #1;
   endtask
endmodule

// file: bench/testbench.sv
// Self-checking bench for the dual-port RAM controller.
// Assumes the bus master model and bound checker are compiled first.
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; \
   $display("ERROR %0t got %h want %h", $time, a, b); end end
module testbench;
   logic clk = 1'b0, reset = 1'b1, expansion_fitted = 1'b0;
   logic battery_power = 1'b0, hide_enable = 1'b1, local_req = 1'b0;
   logic [6:0] bus_base_jumper = 7'h05;
   logic [2:0] hide_first_seg = 3'h2, hide_last_seg = 3'h3;
   logic local_write = 1'b0, local_ack, bus_req, bus_write, bus_byte;
   logic bus_ack, refresh_busy;
   logic [15:0] local_addr = 16'h0000, local_wdata = 16'h0000;
   logic [15:0] local_rdata, bus_wdata, bus_rdata, d, a;
   logic [19:0] bus_addr, base;
   logic [15:0] mem [0:32767];
   int n_errors = 0, checked = 0, nref = 0, k;
   always #50 clk = ~clk;
   always @(posedge clk) if (refresh_busy === 1'b1) nref++;
   dprc_ctrl #(.REFRESH_CYCLES(8)) i_dprc_ctrl (.clk, .reset,
      .expansion_fitted, .battery_power, .bus_base_jumper, .hide_first_seg,
      .hide_last_seg, .hide_enable, .local_req, .local_write, .local_addr,
      .local_wdata, .local_ack, .local_rdata, .bus_req, .bus_write,
      .bus_byte, .bus_addr, .bus_wdata, .bus_ack, .bus_rdata, .refresh_busy);
   dprc_bus_master i_dprc_bus_master (.clk, .bus_ack, .bus_rdata, .bus_req,
      .bus_write, .bus_byte, .bus_addr, .bus_wdata);
   task automatic wrap_up;
      if (n_errors == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic lcl(input logic wr, input logic [15:0] ad, wd,
      input logic ex);
      int i;
      logic got;
      got = 1'b0;
      @(posedge clk) #1;
      local_write = wr;
      local_addr = ad;
      local_wdata = wd;
      local_req = 1'b1;
      for (i = 0; i < 20 && !got; i++) begin
         @(posedge clk);
         got = (local_ack === 1'b1);
      end
      d = local_rdata;
      #1 local_req = 1'b0;
      local_wdata = ~wd;
      `CHK(got, ex)
      if (got && wr) mem[ad[15:1]] = wd;
      if (got && !wr) `CHK(d, mem[ad[15:1]])
   endtask
   task automatic bxf(input logic wr, bt, input logic [19:0] off,
      input logic [15:0] wd, input logic ex);
      logic got;
      logic [15:0] r, m;
      i_dprc_bus_master.xfer(wr, bt, base + off, wd, got, r);
      `CHK(got, ex)
      m = mem[off[15:1]];
      if (got && wr && !bt) mem[off[15:1]] = wd;
      if (got && wr && bt) mem[off[15:1]] = off[0] ? {wd[7:0], m[7:0]}
         : {m[15:8], wd[7:0]};
      if (got && !wr && bt) `CHK(r[7:0], off[0] ? m[15:8] : m[7:0])
      if (got && !wr && !bt) `CHK(r, m)
   endtask
   initial begin
      void'($urandom(83));
      repeat (20) @(posedge clk);
      #1 reset = 1'b0;
      bus_base_jumper = 7'($urandom_range(1, 127));
      base = {bus_base_jumper, 13'h0000};
      repeat (4) @(posedge clk);
      for (k = 0; k < 4; k++) begin
         a = 16'($urandom_range(0, 16383)) << 1;
         lcl(1'b1, a, 16'($urandom), 1'b1);
         lcl(1'b0, a, 16'h0000, 1'b1);
      end
      bxf(1'b1, 1'b0, 20'h00200, 16'($urandom), 1'b1);
      lcl(1'b0, 16'h0200, 16'h0000, 1'b1);
      bxf(1'b1, 1'b1, 20'h00201, 16'($urandom), 1'b1);
      lcl(1'b0, 16'h0200, 16'h0000, 1'b1);
      bxf(1'b0, 1'b1, 20'h00200, 16'h0000, 1'b1);
      fork
         bxf(1'b0, 1'b0, 20'h00200, 16'h0000, 1'b1);
         begin
            // Local request lands on the edge the bus request is seen
            repeat (2) @(posedge clk);
            lcl(1'b0, 16'h0200, 16'h0000, 1'b1);
         end
      join
      bxf(1'b1, 1'b0, 20'h04000, 16'h1234, 1'b0);
      bxf(1'b0, 1'b0, 20'hffffe, 16'h0000, 1'b0);
      lcl(1'b1, 16'h9000, 16'h4321, 1'b0);
      expansion_fitted = 1'b1;
      repeat (4) @(posedge clk);
      lcl(1'b1, 16'h9000, 16'($urandom), 1'b1);
      bxf(1'b0, 1'b0, 20'h09000, 16'h0000, 1'b0);
      hide_enable = 1'b0;
      bxf(1'b0, 1'b0, 20'h09000, 16'h0000, 1'b1);
      battery_power = 1'b1;
      nref = 0;
      repeat (5) @(posedge clk);
      lcl(1'b0, 16'h0200, 16'h0000, 1'b0);
      bxf(1'b0, 1'b0, 20'h00200, 16'h0000, 1'b0);
      `CHK(nref > 2, 1'b1)
      wrap_up;
   end
   // Whole run is a few hundred cycles
   initial begin
      #3000000;
      n_errors++;
      wrap_up;
   end
endmodule
